// [pkg/srss_defines.svh]
// register offsets, field positions, codes and reset values of the
// system configuration unit; included by the package and the assertions
`ifndef SRSS_DEFINES_SVH
`define SRSS_DEFINES_SVH

`define SRSS_ADDR_W          8
`define SRSS_DATA_W          32
`define SRSS_CFG_OFFSET      8'h00
`define SRSS_WORD_ZERO       32'h0000_0000

`define SRSS_MEM_MAP_LSB     0
`define SRSS_MEM_MAP_MSB     1
`define SRSS_T1_CAP_LSB      2
`define SRSS_T1_CAP_MSB      3
`define SRSS_T2_CAP_LSB      4
`define SRSS_T2_CAP_MSB      5
`define SRSS_T3_CAP_LSB      6
`define SRSS_T3_CAP_MSB      7
`define SRSS_T1_TRIG_LSB     8
`define SRSS_T1_TRIG_MSB     10
`define SRSS_T2_TRIG_LSB     12
`define SRSS_T2_TRIG_MSB     14
`define SRSS_T3_TRIG_LSB     16
`define SRSS_T3_TRIG_MSB     18
`define SRSS_GPIO_AHB_BIT    24

`define SRSS_TRIG_GPIO       3'h0
`define SRSS_TRIG_COMPARATOR_ONE      3'h1
`define SRSS_TRIG_COMPARATOR_TWO      3'h2
`define SRSS_TRIG_ADC        3'h3

`define SRSS_CAP_PIN         2'h0
`define SRSS_CAP_COMPARATOR_ONE       2'h1
`define SRSS_CAP_COMPARATOR_TWO       2'h2

`define SRSS_MAP_SYS_FLASH   2'h1
`define SRSS_MAP_SRAM        2'h3

`define SRSS_MAP_RESET       2'h0
`define SRSS_CAP_RESET       2'h0
`define SRSS_TRIG_RESET      3'h0
`define SRSS_BIT_RESET       1'h0
`define SRSS_TIMERS          3

`endif

// [pkg/srss_pkg.sv]
// types of the system configuration unit
// assumes srss_defines.svh is on the include path
`include "srss_defines.svh"

package srss_pkg;

    typedef struct packed {
        logic [`SRSS_ADDR_W-1:0] addr;
        logic [`SRSS_DATA_W-1:0] wdata;
        logic                    wr;
        logic                    rd;
    } srss_bus_req_type;

    typedef struct packed {
        logic       gpio_ahb_sel;
        logic [2:0] t3_trigger_source;
        logic [2:0] t2_trigger_source;
        logic [2:0] t1_trigger_source;
        logic [1:0] t3_capture1_source;
        logic [1:0] t2_capture4_source;
        logic [1:0] t1_capture1_source;
        logic [1:0] mem_map;
    } srss_config_type;

    typedef enum logic {
        BOOT_LOAD,
        BOOT_DONE
    } srss_boot_state_type;

endpackage

// [sim/srss_assertions.sv]
// assertions on the ports of the system configuration unit
// bound into the unit; a shadow of written fields tracks the register
`timescale 1ns/10ps
`include "srss_defines.svh"
module srss_assertions
    import srss_pkg::*;
(
    input wire logic             ref_clk,                // clock
    input wire logic             rstn,                   // reset
    input wire srss_bus_req_type bus_req,                // bus
    input wire logic [31:0]      bus_rdata,              // read data
    input wire logic [1:0]       boot_mode,              // boot
    input wire logic [2:0]       trigger_pin,            // pins
    input wire logic [2:0]       capture_pin,            // pins
    input wire logic             comparator_one,         // source
    input wire logic             comparator_two,         // source
    input wire logic             adc_trigger,            // source
    input wire logic [1:0]       mem_map_select,         // map
    input wire logic             map_main_flash,         // decode
    input wire logic             map_system_flash,       // decode
    input wire logic             map_sram,               // decode
    input wire logic             gpio_ahb_select,        // path
    input wire logic [2:0]       external_trigger_input, // routed
    input wire logic [2:0]       capture_input           // routed
);
    logic        booted;
    logic [31:0] sh;
    logic [2:0]  sq;
    logic [2:0]  tq;
    logic [2:0]  cq;
    wire         hit_wr = bus_req.wr && bus_req.addr == 8'h00;
    wire         hit_rd = bus_req.rd && bus_req.addr == 8'h00;
    // booted hides the boot-load edge from the stability checks
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            booted <= 1'b0;
            sh <= 32'h0;
            {sq, tq, cq} <= 9'h0;
        end
        else
        begin
            booted <= 1'b1;
            {sq, tq, cq} <= {adc_trigger, comparator_two, comparator_one,
                             trigger_pin, capture_pin};
            if (hit_wr)
                sh <= bus_req.wdata & 32'h0107_77ff;
        end
    end
    function automatic logic pick(logic [2:0] c, logic [3:0] s);
        return (c < 3'h4) ? s[c[1:0]] : 1'b0;
    endfunction
    property p_decode;
        @(posedge ref_clk) disable iff (!rstn)
        map_main_flash == !mem_map_select[0] && map_system_flash == (mem_map_select == 2'h1)
            && map_sram == (mem_map_select == 2'h3);
    endproperty
    a_decode: assert property (p_decode) else $error("map decode wrong");
    property p_boot;
        @(posedge ref_clk) disable iff (!rstn)
        rstn && !booted && !hit_wr |=> mem_map_select == $past(boot_mode) && !gpio_ahb_select;
    endproperty
    a_boot: assert property (p_boot) else $error("boot load wrong");
    property p_write;
        @(posedge ref_clk) disable iff (!rstn)
        hit_wr |=> mem_map_select == $past(bus_req.wdata[1:0])
            && gpio_ahb_select == $past(bus_req.wdata[24]);
    endproperty
    a_write: assert property (p_write) else $error("write not applied");
    property p_hold;
        @(posedge ref_clk) disable iff (!rstn)
        booted && !hit_wr |=> $stable(mem_map_select) && $stable(gpio_ahb_select);
    endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    property p_rd_hit;
        @(posedge ref_clk) disable iff (!rstn)
        hit_rd && booted |=> bus_rdata == {$past(sh[31:2]), $past(mem_map_select)};
    endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("read data wrong");
    property p_rd_zero;
        @(posedge ref_clk) disable iff (!rstn)
        !hit_rd |=> bus_rdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
    for (genvar i = 0; i < 3; i++)
    begin : g_route
        property p_trig;
            @(posedge ref_clk) disable iff (!rstn)
            booted |-> external_trigger_input[i] == pick(sh[8+4*i+:3], {sq, tq[i]});
        endproperty
        a_trig: assert property (p_trig) else $error("trigger wrong");
        property p_cap;
            @(posedge ref_clk) disable iff (!rstn)
            booted |-> capture_input[i] == pick({1'b0, sh[2+2*i+:2]}, {1'b0, sq[1:0], cq[i]});
        endproperty
        a_cap: assert property (p_cap) else $error("capture wrong");
    end
endmodule

bind srss_system_config_unit srss_assertions u_chk
(
    .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .boot_mode(boot_mode), .trigger_pin(trigger_pin), .capture_pin(capture_pin),
    .comparator_one(comparator_one), .comparator_two(comparator_two),
    .adc_trigger(adc_trigger), .mem_map_select(mem_map_select),
    .map_main_flash(map_main_flash), .map_system_flash(map_system_flash),
    .map_sram(map_sram), .gpio_ahb_select(gpio_ahb_select),
    .external_trigger_input(external_trigger_input), .capture_input(capture_input)
);

// [sim/srss_source_model.sv]
// sources facing the unit: gpio pins, comparators, adc event
// levels change right after each rising edge, so every cycle is fresh
`timescale 1ns/10ps
module srss_source_model
(
    input  wire logic ref_clk,  // clock
    output logic [8:0] levels   // adc, comp two, comp one, trig, cap
);
    int seed = 32'hd281d8b1;
    initial levels = 9'h0;
    always @(posedge ref_clk)
        levels <= 9'($random(seed));
endmodule

// [sim/system_remap_and_timer_source_select_tb.sv]
// self-checking bench of the system configuration unit
// a word model predicts every output; compared at each falling edge
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module system_remap_and_timer_source_select_tb;
    import srss_pkg::*;
    logic             ref_clk = 1'b0;
    logic             rstn    = 1'b0;
    srss_bus_req_type req     = '0;
    logic [1:0]       boot    = 2'h0;
    logic [31:0]      rdata;
    logic [31:0]      cfg     = '0;
    logic [31:0]      e_rd    = '0;
    logic [2:0]       e_t     = '0;
    logic [2:0]       e_c     = '0;
    logic             booted  = 1'b0;
    logic [8:0]       src;
    logic [1:0]       map;
    logic [2:0]       dec;
    logic             gpio;
    logic [2:0]       trig;
    logic [2:0]       cap;
    logic [31:0]      w;
    int               errors   = 0;
    int               compares = 0;
    int               seed     = 32'hd281d8b1;
    int               i;
    always #25 ref_clk = ~ref_clk;
    srss_system_config_unit uut
    (
        .ref_clk(ref_clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
        .boot_mode(boot), .trigger_pin(src[5:3]), .capture_pin(src[2:0]),
        .comparator_one(src[6]), .comparator_two(src[7]), .adc_trigger(src[8]),
        .mem_map_select(map), .map_main_flash(dec[2]), .map_system_flash(dec[1]),
        .map_sram(dec[0]), .gpio_ahb_select(gpio),
        .external_trigger_input(trig), .capture_input(cap)
    );
    srss_source_model u_src
    (
        .ref_clk(ref_clk), .levels(src)
    );
    function automatic logic pick(logic [2:0] c, logic [3:0] s);
        return (c < 3'h4) ? s[c[1:0]] : 1'b0;
    endfunction
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg = '0;
            e_rd = '0;
            e_t = '0;
            e_c = '0;
            booted = 1'b0;
        end
        else
        begin
            e_rd = (req.rd && req.addr == 8'h00) ? cfg : 32'h0;
            if (!booted)
                cfg[1:0] = boot;
            booted = 1'b1;
            // write wins over the boot load
            if (req.wr && req.addr == 8'h00)
                cfg = req.wdata & 32'h0107_77ff;
            for (int k = 0; k < 3; k++)
            begin
                e_t[k] = pick(cfg[8+4*k+:3], {src[8:6], src[3+k]});
                e_c[k] = pick({1'b0, cfg[2+2*k+:2]}, {1'b0, src[7:6], src[k]});
            end
        end
    end
    always @(negedge ref_clk)
    begin
        `CHK(map, cfg[1:0])
        `CHK(dec, {!cfg[0], cfg[1:0] == 2'h1, cfg[1:0] == 2'h3})
        `CHK(gpio, cfg[24])
        `CHK(trig, e_t)
        `CHK(cap, e_c)
        `CHK(rdata, e_rd)
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: wr, rd: !wr};
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk) req <= '0;
    endtask
    // reset with a boot mode, optionally writing at the first edge after release
    task automatic rst(input logic [1:0] b, input logic [31:0] d, input logic wr);
        @(posedge ref_clk);
        rstn <= 1'b0;
        boot <= b;
        req <= '0;
        repeat (7) @(posedge ref_clk);
        rstn <= 1'b1;
        req <= '{addr: 8'h00, wdata: d, wr: wr, rd: 1'b0};
        idle(3);
        bus(1'b0, 8'h00, 32'h0);
        idle(2);
    endtask
    task automatic results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        results();
    end
    initial
    begin
        for (i = 0; i < 4; i++)
            rst(i[1:0], 32'h0, 1'b0);
        rst(2'h3, 32'h0100_0001, 1'b1);
        $display("test boot done");
        for (i = 0; i < 4; i++)
        begin
            bus(1'b1, 8'h00, i);
            bus(1'b0, 8'h00, 32'h0);
        end
        $display("test map done");
        for (i = 0; i < 8; i++)
        begin
            w = (((i + 2) % 8) << 8) | (((i + 1) % 8) << 12) | (i << 16) | (i << 24);
            w = w | ((i % 4) << 2) | (((i + 1) % 4) << 4) | (((i + 2) % 4) << 6);
            bus(1'b1, 8'h00, w);
            idle(6);
        end
        $display("test routing done");
        bus(1'b1, 8'h04, 32'hffff_ffff);
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b1, 8'h80, 32'h0);
        bus(1'b1, 8'h00, 32'hffff_ffff);
        bus(1'b0, 8'h00, 32'h0);
        idle(2);
        $display("test reserved done");
        repeat (40)
            bus(1'($random(seed)), {5'h0, 1'($random(seed)), 2'h0}, $random(seed));
        idle(4);
        $display("test random done");
        results();
    end
endmodule

// [verilog/srss_system_config_unit.sv]
// system configuration unit: remap select, gpio path select and
// routing of timer trigger and capture inputs
// assumes one clock, bus inputs synchronous to ref_clk, boot_mode stable
// around reset release
//
// What this block does
// - two-bit map field picks main flash, system flash or sram at zero
// - after reset the map field loads sampled boot mode; others clear
// - software write to the map field changes the remap at once
// - bit 24 steers gpio access: 0 single-cycle port, 1 ahb bus
// - timer three trigger field: gpio, comparator one, two, adc
// - timer two trigger field uses the same zero-to-three encoding
// - timer one trigger field routes gpio, comparators or adc
// - bits 7:6 pick timer three capture one: pin, comparator one, two
// - bits 5:4 pick timer two capture four: pin, comparator one, two
// - bits 3:2 pick timer one capture one: pin, comparator one, two
//
// Strobed register access was left to the implementer.

`timescale 1ns/10ps

module srss_system_config_unit
    import srss_pkg::*;
(
    input  wire logic                    ref_clk,          // 20 MHz clock
    input  wire logic                    rstn,             // async reset, low
    input  wire srss_bus_req_type        bus_req,          // register request
    output logic [`SRSS_DATA_W-1:0]      bus_rdata,        // read data
    input  wire logic [1:0]              boot_mode,        // sampled boot mode
    input  wire logic [`SRSS_TIMERS-1:0] trigger_pin,      // gpio trigger pins
    input  wire logic [`SRSS_TIMERS-1:0] capture_pin,      // capture pins
    input  wire logic                    comparator_one,   // comparator output
    input  wire logic                    comparator_two,   // comparator output
    input  wire logic                    adc_trigger,      // adc event
    output logic [1:0]                   mem_map_select,   // map field
    output logic                         map_main_flash,   // flash at zero
    output logic                         map_system_flash, // boot rom at zero
    output logic                         map_sram,         // sram at zero
    output logic                         gpio_ahb_select,  // 1 ahb path
    output logic [`SRSS_TIMERS-1:0]      external_trigger_input, // to timers
    output logic [`SRSS_TIMERS-1:0]      capture_input     // to timers
);

    srss_config_type             cfg;
    srss_config_type             next_cfg;
    srss_boot_state_type         boot_state;
    srss_boot_state_type         next_boot_state;
    logic [`SRSS_DATA_W-1:0]     next_rdata;
    logic                        next_main;
    logic                        next_sys;
    logic                        next_sram;
    logic [`SRSS_TIMERS-1:0]     next_trig;
    logic [`SRSS_TIMERS-1:0]     next_cap;
    logic [2:0]                  trig_code [`SRSS_TIMERS];
    logic [1:0]                  cap_code  [`SRSS_TIMERS];
    logic                        cfg_hit;
    logic                        cfg_wr;
    logic                        cfg_rd;
    logic                        boot_load;

    // reserved trigger codes fall to the default branch and read low
    function automatic logic trig_mux(
        input logic [2:0] code,
        input logic       pin,
        input logic       c1,
        input logic       c2,
        input logic       adc
    );
        logic result;
        result = 1'b0;
        case (code)
            `SRSS_TRIG_GPIO:  result = pin;
            `SRSS_TRIG_COMPARATOR_ONE: result = c1;
            `SRSS_TRIG_COMPARATOR_TWO: result = c2;
            `SRSS_TRIG_ADC:   result = adc;
            default:          result = 1'b0;
        endcase
        return result;
    endfunction

    function automatic logic cap_mux(
        input logic [1:0] code,
        input logic       pin,
        input logic       c1,
        input logic       c2
    );
        logic result;
        result = 1'b0;
        case (code)
            `SRSS_CAP_PIN:   result = pin;
            `SRSS_CAP_COMPARATOR_ONE: result = c1;
            `SRSS_CAP_COMPARATOR_TWO: result = c2;
            default:         result = 1'b0;
        endcase
        return result;
    endfunction

    // only defined fields are packed back; every reserved bit stays zero
    function automatic logic [`SRSS_DATA_W-1:0] cfg_word(
        input srss_config_type c
    );
        logic [`SRSS_DATA_W-1:0] w;
        w = `SRSS_WORD_ZERO;
        w[`SRSS_MEM_MAP_MSB:`SRSS_MEM_MAP_LSB] = c.mem_map;
        w[`SRSS_T1_CAP_MSB:`SRSS_T1_CAP_LSB]   = c.t1_capture1_source;
        w[`SRSS_T2_CAP_MSB:`SRSS_T2_CAP_LSB]   = c.t2_capture4_source;
        w[`SRSS_T3_CAP_MSB:`SRSS_T3_CAP_LSB]   = c.t3_capture1_source;
        w[`SRSS_T1_TRIG_MSB:`SRSS_T1_TRIG_LSB] = c.t1_trigger_source;
        w[`SRSS_T2_TRIG_MSB:`SRSS_T2_TRIG_LSB] = c.t2_trigger_source;
        w[`SRSS_T3_TRIG_MSB:`SRSS_T3_TRIG_LSB] = c.t3_trigger_source;
        w[`SRSS_GPIO_AHB_BIT]                  = c.gpio_ahb_sel;
        return w;
    endfunction

    // an unmapped address is ignored on write and reads back zero
    assign cfg_hit = (bus_req.addr == `SRSS_CFG_OFFSET);
    assign cfg_wr  = bus_req.wr && cfg_hit;
    assign cfg_rd  = bus_req.rd && cfg_hit;

    // boot load: one cycle after reset release the map field takes boot_mode
    always_comb
    begin
        next_boot_state = boot_state;
        boot_load       = 1'b0;
        case (boot_state)
            BOOT_LOAD:
            begin
                boot_load       = 1'b1;
                next_boot_state = BOOT_DONE;
            end
            BOOT_DONE:
            begin
                next_boot_state = BOOT_DONE;
            end
            default:
            begin
                // an illegal state falls back to normal running
                next_boot_state = BOOT_DONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_state <= BOOT_LOAD;
        end
        else
        begin
            boot_state <= next_boot_state;
        end
    end

    // register state
    always_comb
    begin
        next_cfg = cfg;
        if (boot_load)
        begin
            next_cfg.mem_map = boot_mode;
        end
        // a write in the load cycle wins: software overrides the boot pick
        if (cfg_wr)
        begin
            next_cfg.mem_map =
                bus_req.wdata[`SRSS_MEM_MAP_MSB:`SRSS_MEM_MAP_LSB];
            next_cfg.t1_capture1_source =
                bus_req.wdata[`SRSS_T1_CAP_MSB:`SRSS_T1_CAP_LSB];
            next_cfg.t2_capture4_source =
                bus_req.wdata[`SRSS_T2_CAP_MSB:`SRSS_T2_CAP_LSB];
            next_cfg.t3_capture1_source =
                bus_req.wdata[`SRSS_T3_CAP_MSB:`SRSS_T3_CAP_LSB];
            next_cfg.t1_trigger_source =
                bus_req.wdata[`SRSS_T1_TRIG_MSB:`SRSS_T1_TRIG_LSB];
            next_cfg.t2_trigger_source =
                bus_req.wdata[`SRSS_T2_TRIG_MSB:`SRSS_T2_TRIG_LSB];
            next_cfg.t3_trigger_source =
                bus_req.wdata[`SRSS_T3_TRIG_MSB:`SRSS_T3_TRIG_LSB];
            next_cfg.gpio_ahb_sel = bus_req.wdata[`SRSS_GPIO_AHB_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg.mem_map            <= `SRSS_MAP_RESET;
            cfg.t1_capture1_source <= `SRSS_CAP_RESET;
            cfg.t2_capture4_source <= `SRSS_CAP_RESET;
            cfg.t3_capture1_source <= `SRSS_CAP_RESET;
            cfg.t1_trigger_source  <= `SRSS_TRIG_RESET;
            cfg.t2_trigger_source  <= `SRSS_TRIG_RESET;
            cfg.t3_trigger_source  <= `SRSS_TRIG_RESET;
            cfg.gpio_ahb_sel       <= `SRSS_BIT_RESET;
        end
        else
        begin
            cfg <= next_cfg;
        end
    end

    // read path; unmapped reads return zero
    always_comb
    begin
        next_rdata = `SRSS_WORD_ZERO;
        if (cfg_rd)
        begin
            next_rdata = cfg_word(cfg);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_rdata <= `SRSS_WORD_ZERO;
        end
        else
        begin
            bus_rdata <= next_rdata;
        end
    end

    // remap decode from the next value so the map follows the field
    always_comb
    begin
        next_main = 1'b0;
        next_sys  = 1'b0;
        next_sram = 1'b0;
        // only bit 0 tells main flash apart, so code 10 maps main flash too
        case (next_cfg.mem_map)
            `SRSS_MAP_SYS_FLASH: next_sys  = 1'b1;
            `SRSS_MAP_SRAM:      next_sram = 1'b1;
            default:             next_main = 1'b1;
        endcase
    end

    // timer source codes as arrays for the routing loop
    assign trig_code[0] = next_cfg.t1_trigger_source;
    assign trig_code[1] = next_cfg.t2_trigger_source;
    assign trig_code[2] = next_cfg.t3_trigger_source;
    assign cap_code[0]  = next_cfg.t1_capture1_source;
    assign cap_code[1]  = next_cfg.t2_capture4_source;
    assign cap_code[2]  = next_cfg.t3_capture1_source;

    // index 0 timer one, 1 timer two, 2 timer three
    genvar gi;
    generate
        for (gi = 0; gi < `SRSS_TIMERS; gi++)
        begin : g_route
            always_comb
            begin
                next_trig[gi] = trig_mux(trig_code[gi],
                                         trigger_pin[gi],
                                         comparator_one,
                                         comparator_two,
                                         adc_trigger);
                next_cap[gi]  = cap_mux(cap_code[gi],
                                        capture_pin[gi],
                                        comparator_one,
                                        comparator_two);
            end
        end
    endgenerate

    // remap outputs follow next_cfg so a write shows right after its edge
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_map_select         <= `SRSS_MAP_RESET;
            map_main_flash         <= 1'b1;
            map_system_flash       <= 1'b0;
            map_sram               <= 1'b0;
            gpio_ahb_select        <= `SRSS_BIT_RESET;
        end
        else
        begin
            mem_map_select         <= next_cfg.mem_map;
            map_main_flash         <= next_main;
            map_system_flash       <= next_sys;
            map_sram               <= next_sram;
            gpio_ahb_select        <= next_cfg.gpio_ahb_sel;
        end
    end

    // routed signals cost one cycle of latency so every output is a flop
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            external_trigger_input <= '0;
            capture_input          <= '0;
        end
        else
        begin
            external_trigger_input <= next_trig;
            capture_input          <= next_cap;
        end
    end

endmodule
